// *** common/host_uart_cfg.svh ***
`ifndef HOST_UART_CFG_SVH
`define HOST_UART_CFG_SVH

// ==========================================
// clock and rates
`define CLK_HZ               40000000
`define BAUD_MIN_BPS         9600
`define BAUD_MAX_BPS         921600
`define BAUD_RESET_BPS       115200
`define BAUD_SEC_BPS         9600
`define DIV_RESET            (`CLK_HZ / `BAUD_RESET_BPS)
`define DIV_SEC              (`CLK_HZ / `BAUD_SEC_BPS)
`define DIV_MIN              (`CLK_HZ / `BAUD_MAX_BPS)
`define DIV_MAX              (`CLK_HZ / `BAUD_MIN_BPS)

// ==========================================
// frame and gaps
`define DATA_BITS            8
`define GAP_CHARS_RESET      12
`define CHAR_BITS            10
`define RX_TIMEOUT_CHARS     4

// ==========================================
// wake-up lead time
`define WAKE_LEAD_MS         10
`define WAKE_LEAD_CYCLES     (`CLK_HZ / 1000 * `WAKE_LEAD_MS)

`endif

// *** common/host_uart_pkg.sv ***
package host_uart_pkg;
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_WAKE  = 2'b01,
    TX_SHIFT = 2'b10,
    TX_GAP   = 2'b11
  } tx_state_t;
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_t;
  typedef logic [7:0] byte_t;
endpackage

// *** rtl/host_uart_link.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "host_uart_cfg.svh"
// What this block does
// - frames are start bit, eight data bits lsb first, one stop, no parity
// - full duplex; two-wire or four-wire selectable
// - main channel rate programmable 9600 to 921.6 kbps, reset 115.2 kbps
// - secondary channel fixed 9600 bps, no flow control, no wake-up
// - in hci mode a command moves data onto secondary pin pair
// - at least twelve character gap between messages, gap adjustable
// - flag character timeout, overrun and framing errors
// - flow control off at reset, main channel only, two gating pins
// - wake pin asserted lead time before sending, 10 ms default, off
// - after reset shared pins come up as a two-wire port
// - in hci mode the port serves as the host command interface
module host_uart_link #(
  parameter int WAKE_CYCLES = `WAKE_LEAD_CYCLES
) (
  input  wire logic                      ref_clk_i,
  input  wire logic                      reset_i,
  // configuration
  input  wire logic [15:0]               baud_div_i,
  input  wire logic                      baud_load_i,
  input  wire logic                      four_wire_i,
  input  wire logic                      hci_mode_i,
  input  wire logic                      use_secondary_i,
  input  wire logic                      wake_en_i,
  input  wire logic [1:0]                wake_pin_sel_i,
  input  wire logic [31:0]               wake_cycles_i,
  input  wire logic [7:0]                gap_chars_i,
  input  wire logic                      gap_load_i,
  // transmit data
  input  wire host_uart_pkg::byte_t      tx_data_i,
  input  wire logic                      tx_valid_i,
  input  wire logic                      tx_msg_end_i,
  output logic                           tx_ready_o,
  // receive data
  output host_uart_pkg::byte_t           rx_data_o,
  output logic                           rx_valid_o,
  input  wire logic                      rx_ready_i,
  input  wire logic                      rx_almost_full_i,
  // status
  output logic                           err_timeout_o,
  output logic                           err_overrun_o,
  output logic                           err_framing_o,
  input  wire logic                      err_clear_i,
  output logic                           sec_active_o,
  output logic                           hci_cmd_port_o,
  // shared pins three to six
  input  wire logic [3:0]                shared_pin_in_i,
  output logic [3:0]                     shared_pin_out_o,
  output logic [3:0]                     shared_pin_oe_o,
  output logic                           wake_pin_o
);
  import host_uart_pkg::*;

  // ==========================================
  // configuration
  logic [15:0] div_reg;
  logic [7:0]  gap_reg;
  logic        sec_reg;
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      div_reg <= 16'(`DIV_RESET);
      gap_reg <= 8'(`GAP_CHARS_RESET);
      sec_reg <= 1'b0;
    end else begin
      if (baud_load_i && baud_div_i >= 16'(`DIV_MIN) &&
          baud_div_i <= 16'(`DIV_MAX)) begin
        div_reg <= baud_div_i;
      end
      if (gap_load_i && gap_chars_i >= 8'(`GAP_CHARS_RESET)) begin
        gap_reg <= gap_chars_i;
      end
      sec_reg <= hci_mode_i & use_secondary_i;
    end
  end
  logic [15:0] bit_div;
  logic        flow_on;
  assign bit_div = sec_reg ? 16'(`DIV_SEC) : div_reg;
  assign flow_on = four_wire_i & ~sec_reg;

  // ==========================================
  // pin synchronisers
  logic [3:0] pin_s;
  pin_sync #(.WIDTH(4), .INIT(1'b1)) u_sync (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .async_i   (shared_pin_in_i),
    .sync_o    (pin_s)
  );
  logic rxd;
  logic permit_in;
  assign rxd       = sec_reg ? pin_s[3] : pin_s[1];
  assign permit_in = ~flow_on | ~pin_s[3];

  // ==========================================
  // transmitter
  tx_state_t   tx_state_reg;
  logic [15:0] tx_cnt_reg;
  logic [3:0]  tx_bit_reg;
  logic [8:0]  tx_sh_reg;
  logic [31:0] tx_tmr_reg;
  logic        tx_last_reg;
  logic        txd_reg;
  logic        wake_reg;
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_state_reg <= TX_IDLE;
      tx_cnt_reg   <= 16'h0000;
      tx_bit_reg   <= 4'h0;
      tx_sh_reg    <= 9'h1ff;
      tx_tmr_reg   <= 32'h0000_0000;
      tx_last_reg  <= 1'b0;
      txd_reg      <= 1'b1;
      wake_reg     <= 1'b0;
      tx_ready_o   <= 1'b0;
    end else begin
      tx_ready_o <= 1'b0;
      case (tx_state_reg)
        TX_IDLE: begin
          txd_reg <= 1'b1;
          if (!wake_en_i) begin
            wake_reg <= 1'b0;
          end
          if (tx_valid_i && permit_in && !tx_ready_o) begin
            tx_sh_reg   <= {tx_data_i, 1'b0};
            tx_last_reg <= tx_msg_end_i;
            tx_ready_o  <= 1'b1;
            if (wake_en_i && !sec_reg && !wake_reg) begin
              wake_reg     <= 1'b1;
              tx_tmr_reg   <= (wake_cycles_i == 32'h0) ?
                              32'(WAKE_CYCLES) : wake_cycles_i;
              tx_state_reg <= TX_WAKE;
            end else begin
              tx_state_reg <= TX_SHIFT;
              tx_cnt_reg   <= bit_div;
              tx_bit_reg   <= 4'h0;
            end
          end
        end
        TX_WAKE: begin
          if (tx_tmr_reg <= 32'h1) begin
            tx_state_reg <= TX_SHIFT;
            tx_cnt_reg   <= bit_div;
            tx_bit_reg   <= 4'h0;
          end else begin
            tx_tmr_reg <= tx_tmr_reg - 32'h1;
          end
        end
        TX_SHIFT: begin
          txd_reg <= tx_sh_reg[0];
          if (tx_cnt_reg <= 16'h1) begin
            tx_cnt_reg <= bit_div;
            tx_sh_reg  <= {1'b1, tx_sh_reg[8:1]};
            if (tx_bit_reg == 4'(`CHAR_BITS - 1)) begin
              if (tx_last_reg) begin
                tx_state_reg <= TX_GAP;
                tx_tmr_reg   <= 32'(gap_reg) * 32'(`CHAR_BITS) *
                                32'(bit_div);
              end else begin
                tx_state_reg <= TX_IDLE;
              end
            end else begin
              tx_bit_reg <= tx_bit_reg + 4'h1;
            end
          end else begin
            tx_cnt_reg <= tx_cnt_reg - 16'h1;
          end
        end
        TX_GAP: begin
          txd_reg  <= 1'b1;
          wake_reg <= 1'b0;
          if (tx_tmr_reg <= 32'h1) begin
            tx_state_reg <= TX_IDLE;
          end else begin
            tx_tmr_reg <= tx_tmr_reg - 32'h1;
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // ==========================================
  // receiver
  rx_state_t   rx_state_reg;
  logic [15:0] rx_cnt_reg;
  logic [2:0]  rx_bit_reg;
  logic [7:0]  rx_sh_reg;
  logic        rxd_prev_reg;
  logic [23:0] rx_idle_reg;
  logic        rx_armed_reg;
  logic        rx_done;
  logic        rx_frame_bad;
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg   <= 16'h0000;
      rx_bit_reg   <= 3'h0;
      rx_sh_reg    <= 8'h00;
      rxd_prev_reg <= 1'b1;
      rx_done      <= 1'b0;
      rx_frame_bad <= 1'b0;
    end else begin
      rxd_prev_reg <= rxd;
      rx_done      <= 1'b0;
      rx_frame_bad <= 1'b0;
      case (rx_state_reg)
        RX_IDLE: begin
          if (rxd_prev_reg && !rxd) begin
            rx_state_reg <= RX_START;
            rx_cnt_reg   <= {1'b0, bit_div[15:1]};
          end
        end
        RX_START: begin
          if (rx_cnt_reg <= 16'h1) begin
            rx_cnt_reg   <= bit_div;
            rx_bit_reg   <= 3'h0;
            rx_state_reg <= rxd ? RX_IDLE : RX_DATA;
          end else begin
            rx_cnt_reg <= rx_cnt_reg - 16'h1;
          end
        end
        RX_DATA: begin
          if (rx_cnt_reg <= 16'h1) begin
            rx_cnt_reg <= bit_div;
            rx_sh_reg  <= {rxd, rx_sh_reg[7:1]};
            rx_bit_reg <= rx_bit_reg + 3'h1;
            if (rx_bit_reg == 3'h7) begin
              rx_state_reg <= RX_STOP;
            end
          end else begin
            rx_cnt_reg <= rx_cnt_reg - 16'h1;
          end
        end
        RX_STOP: begin
          if (rx_cnt_reg <= 16'h1) begin
            rx_state_reg <= RX_IDLE;
            rx_done      <= rxd;
            rx_frame_bad <= ~rxd;
          end else begin
            rx_cnt_reg <= rx_cnt_reg - 16'h1;
          end
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  // ==========================================
  // receive hand-off and errors
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_data_o     <= 8'h00;
      rx_valid_o    <= 1'b0;
      err_timeout_o <= 1'b0;
      err_overrun_o <= 1'b0;
      err_framing_o <= 1'b0;
      rx_idle_reg   <= 24'h000000;
      rx_armed_reg  <= 1'b0;
    end else begin
      if (rx_done && rx_valid_o && !rx_ready_i) begin
        err_overrun_o <= 1'b1;
      end else if (err_clear_i) begin
        err_overrun_o <= 1'b0;
      end
      if (rx_done && !(rx_valid_o && !rx_ready_i)) begin
        rx_data_o  <= rx_sh_reg;
        rx_valid_o <= 1'b1;
      end else if (rx_ready_i) begin
        rx_valid_o <= 1'b0;
      end
      if (rx_frame_bad) begin
        err_framing_o <= 1'b1;
      end else if (err_clear_i) begin
        err_framing_o <= 1'b0;
      end
      if (rx_done) begin
        rx_armed_reg <= 1'b1;
        rx_idle_reg  <= 24'h000000;
      end else if (rx_state_reg != RX_IDLE) begin
        rx_idle_reg <= 24'h000000;
      end else if (rx_armed_reg) begin
        rx_idle_reg <= rx_idle_reg + 24'h1;
      end
      if (rx_armed_reg && rx_idle_reg == 24'(32'(bit_div) *
          32'(`CHAR_BITS * `RX_TIMEOUT_CHARS))) begin
        err_timeout_o <= 1'b1;
        rx_armed_reg  <= 1'b0;
      end else if (err_clear_i) begin
        err_timeout_o <= 1'b0;
      end
    end
  end

  // ==========================================
  // pin drive
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      shared_pin_out_o <= 4'hf;
      shared_pin_oe_o  <= 4'h0;
      wake_pin_o       <= 1'b0;
      sec_active_o     <= 1'b0;
      hci_cmd_port_o   <= 1'b0;
    end else begin
      sec_active_o   <= sec_reg;
      hci_cmd_port_o <= hci_mode_i;
      if (sec_reg) begin
        shared_pin_out_o <= {1'b1, 1'b1, 1'b1, 1'b1};
        shared_pin_out_o[2] <= txd_reg;
        shared_pin_oe_o  <= 4'b0100;
      end else begin
        shared_pin_out_o[0] <= txd_reg;
        shared_pin_out_o[1] <= 1'b1;
        shared_pin_out_o[2] <= ~flow_on | rx_almost_full_i;
        shared_pin_out_o[3] <= 1'b1;
        shared_pin_oe_o     <= {1'b0, flow_on, 1'b0, 1'b1};
      end
      wake_pin_o <= wake_reg & wake_en_i &
                    (wake_pin_sel_i != 2'b11);
    end
  end
endmodule
`default_nettype wire

// *** rtl/pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int          WIDTH = 1,
  parameter logic [0:0]  INIT  = 1'b1
) (
  input  wire logic             ref_clk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_reg <= {WIDTH{INIT}};
      sync_o   <= {WIDTH{INIT}};
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// *** testbench/host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // ============
  // serial lines
  input  wire logic ref_clk_i,
  input  wire logic line_i,
  output logic      line_o
);
  import host_uart_pkg::*;
  int    div = 347;
  int    n = 0;
  byte_t got;
  initial line_o = 1'b1;
  // ============
  // receiver, mid-bit sampling
  initial begin
    forever begin
      @(negedge line_i);
      repeat (div / 2) @(posedge ref_clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (div) @(posedge ref_clk_i);
        got[i] = line_i;
      end
      repeat (div) @(posedge ref_clk_i);
      n++;
    end
  end
  // ============
  // sender, idle high
  task automatic send(input byte_t b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_o = f[i];
      repeat (div) @(posedge ref_clk_i);
      #2;
    end
    if (!stop) line_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// *** testbench/host_uart_link_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_uart_link_checker (
  // ============
  // watched ports
  input  wire logic                 ref_clk_i,
  input  wire logic                 reset_i,
  input  wire logic                 four_wire_i,
  input  wire logic                 hci_mode_i,
  input  wire logic                 wake_en_i,
  input  wire logic                 rx_ready_i,
  input  wire logic                 rx_almost_full_i,
  input  wire logic                 err_clear_i,
  input  wire logic [3:0]           shared_pin_in_i,
  input  wire logic                 tx_ready_o,
  input  wire host_uart_pkg::byte_t rx_data_o,
  input  wire logic                 rx_valid_o,
  input  wire logic                 err_timeout_o,
  input  wire logic                 err_overrun_o,
  input  wire logic                 err_framing_o,
  input  wire logic                 sec_active_o,
  input  wire logic                 hci_cmd_port_o,
  input  wire logic [3:0]           shared_pin_out_o,
  input  wire logic [3:0]           shared_pin_oe_o,
  input  wire logic                 wake_pin_o
);
  import host_uart_pkg::*;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  logic [2:0] errs;
  assign errs = {err_timeout_o, err_overrun_o, err_framing_o};
  sequence s_blocked;
    (four_wire_i && shared_pin_in_i[3])[*5];
  endsequence
  sequence s_accept;
    tx_ready_o && !wake_en_i && !sec_active_o;
  endsequence
  a_ready_pulse: assert property (
    tx_ready_o |=> !tx_ready_o) else $error("ready too long");
  a_start_bit: assert property (
    s_accept |-> ##2 !shared_pin_out_o[0]) else $error("no start bit");
  a_rx_hold: assert property (
    rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
    else $error("rx data lost");
  a_err_sticky: assert property (
    !err_clear_i |=> (errs & $past(errs)) == $past(errs))
    else $error("error flag dropped");
  a_hci_follow: assert property (
    hci_cmd_port_o == $past(hci_mode_i)) else $error("hci port lag");
  a_two_wire_oe: assert property (
    !$past(reset_i) && !four_wire_i && !$past(four_wire_i)
    && !sec_active_o |-> shared_pin_oe_o == 4'h1)
    else $error("two-wire enables");
  a_permit_drop: assert property (
    four_wire_i && rx_almost_full_i |-> ##[1:4] shared_pin_out_o[2])
    else $error("permit not dropped");
  a_flow_block: assert property (
    s_blocked |-> !tx_ready_o) else $error("sent while blocked");
  a_wake_off: assert property (
    !wake_en_i && !$past(wake_en_i) |-> !wake_pin_o)
    else $error("wake while off");
endmodule
bind host_uart_link host_uart_link_checker u_host_uart_link_checker (.*);
`default_nettype wire

// *** testbench/tb_host_uart_link.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_host_uart_link;
  import host_uart_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [15:0] baud_div_i = 16'h0000;
  logic        baud_load_i = 1'b0, four_wire_i = 1'b0, hci_mode_i = 1'b0;
  logic        use_secondary_i = 1'b0, wake_en_i = 1'b0;
  logic [1:0]  wake_pin_sel_i = 2'h0;
  logic [31:0] wake_cycles_i = 32'h0;
  logic [7:0]  gap_chars_i = 8'h0c;
  logic        gap_load_i = 1'b0, tx_valid_i = 1'b0, tx_msg_end_i = 1'b0;
  byte_t       tx_data_i = 8'h00, rx_data_o;
  logic        tx_ready_o, rx_valid_o, rx_ready_i = 1'b0;
  logic        rx_almost_full_i = 1'b0, err_clear_i = 1'b0, permit_n = 1'b0;
  logic        err_timeout_o, err_overrun_o, err_framing_o;
  logic        sec_active_o, hci_cmd_port_o, wake_pin_o, wake_seen;
  logic [3:0]  shared_pin_in_i, shared_pin_out_o, shared_pin_oe_o;
  logic        dev_tx, host_tx;
  int          miscompares = 0, checks = 0, cyc = 0, acc_t, start_t, t0;
  // ============
  // wiring and clock
  assign dev_tx = shared_pin_oe_o[0] ? shared_pin_out_o[0] : 1'b1;
  assign shared_pin_in_i = {permit_n,
    shared_pin_oe_o[2] ? shared_pin_out_o[2] : 1'b1, host_tx, dev_tx};
  host_uart_link #(.WAKE_CYCLES(100)) u_host_uart_link (.*);
  host_model u_host_model (.ref_clk_i(ref_clk_i), .line_i(dev_tx),
    .line_o(host_tx));
  initial forever #12.5 ref_clk_i = ~ref_clk_i;
  always @(negedge dev_tx) begin
    start_t = cyc;
    wake_seen = wake_pin_o;
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 100000) begin
      miscompares++;
      test_done();
    end
  end
  // ============
  // shared tasks
  task automatic check(input logic [31:0] seen, exp, input string what);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    if (miscompares == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk_i);
    #2;
  endtask
  task automatic load(input logic [15:0] d);
    baud_div_i = d;
    baud_load_i = 1'b1;
    tick(1);
    baud_load_i = 1'b0;
    tick(1);
  endtask
  task automatic drain();
    rx_ready_i = 1'b1;
    err_clear_i = 1'b1;
    tick(1);
    rx_ready_i = 1'b0;
    err_clear_i = 1'b0;
  endtask
  task automatic tx_check(input byte_t b, input logic last);
    int n0;
    n0 = u_host_model.n;
    tx_data_i = b;
    tx_msg_end_i = last;
    tx_valid_i = 1'b1;
    do @(posedge ref_clk_i); while (tx_ready_o !== 1'b1);
    acc_t = cyc;
    #2;
    tx_valid_i = 1'b0;
    while (u_host_model.n == n0) @(posedge ref_clk_i);
    #2;
    check(u_host_model.got, b, "host got");
  endtask
  task automatic rx_check(input byte_t b);
    u_host_model.send(b, 1'b1);
    check(rx_valid_o, 1, "rx valid");
    check(rx_data_o, b, "rx data");
    drain();
  endtask
  // ============
  // scenarios
  initial begin
    tick(5);
    reset_i = 1'b0;
    tick(2);
    check(shared_pin_oe_o, 4'h1, "oe");
    check(dev_tx, 1, "idle");
    check({err_timeout_o, err_overrun_o, err_framing_o, sec_active_o,
      wake_pin_o}, 0, "flags");
    fork
      tx_check(8'h5a, 1'b0);
      rx_check(8'ha5);
    join
    u_host_model.send(8'h81, 1'b1);
    u_host_model.send(8'h7e, 1'b1);
    tick(2);
    check(err_overrun_o, 1, "overrun");
    check(rx_data_o, 8'h81, "kept");
    tick(50 * 347);
    check(err_timeout_o, 1, "timeout");
    drain();
    u_host_model.send(8'h42, 1'b0);
    tick(2);
    check(err_framing_o, 1, "framing");
    check(err_overrun_o, 0, "cleared");
    drain();
    load(16'h002b);
    load(16'h002a);
    gap_chars_i = 8'h0b;
    gap_load_i = 1'b1;
    tick(1);
    gap_load_i = 1'b0;
    u_host_model.div = 43;
    tx_check(8'h01, 1'b1);
    t0 = acc_t;
    tx_check(8'h80, 1'b0);
    check(acc_t - t0 >= 13 * 10 * 43, 1, "gap");
    rx_check(8'h3c);
    permit_n = 1'b1;
    tick(3);
    four_wire_i = 1'b1;
    rx_almost_full_i = 1'b1;
    t0 = cyc;
    fork
      tx_check(8'hc3, 1'b0);
      begin
        tick(60);
        check(shared_pin_out_o[2], 1, "permit out");
        check(shared_pin_oe_o, 4'h5, "oe four");
        permit_n = 1'b0;
      end
    join
    check(acc_t - t0 >= 60, 1, "held");
    rx_almost_full_i = 1'b0;
    tick(4);
    check(shared_pin_out_o[2], 0, "permit on");
    four_wire_i = 1'b0;
    wake_en_i = 1'b1;
    wake_cycles_i = 32'h00000064;
    t0 = cyc;
    tx_check(8'h99, 1'b0);
    check(start_t - t0 >= 100, 1, "lead");
    check(wake_seen, 1, "wake pin");
    wake_en_i = 1'b0;
    hci_mode_i = 1'b1;
    tick(2);
    check(hci_cmd_port_o, 1, "hci");
    check(sec_active_o, 0, "sec off");
    tick(6000);
    rx_check(8'h5c);
    permit_n = 1'b1;
    tick(3);
    use_secondary_i = 1'b1;
    tick(2);
    check(sec_active_o, 1, "sec on");
    check(shared_pin_oe_o, 4'h4, "oe sec");
    check(shared_pin_out_o[2], 1, "sec idle");
    test_done();
  end
endmodule
`default_nettype wire
